// ### hw/rre_exec.sv
`timescale 1ns/1ns
// How it works
// - Interrupt return pops stack and loads program counter from top entry.
// - Interrupt return also sets global interrupt enable, bit 7, to one.
// - Interrupt return is one word, two cycles, no status flag change.
// - Subroutine return pops stack into program counter, flags unchanged.
// - Subroutine return takes two instruction cycles.
// - Literal return writes its 8-bit immediate into working register.
// - Literal return also pops stack into the program counter.
// - Literal return is one word and takes two cycles.
// - Rotate left shifts through carry: old carry to bit 0, bit 7 out.
// - Destination bit 0 writes working register, 1 writes file register.
module rre_exec
   import rre_pkg::*;
#(
   parameter int PC_W = 15
) (
   input  wire logic                   ref_clk_in,
   input  wire logic                   rst_n_in,
   input  wire logic                   issue_in,
   input  wire rre_op_t                op_in,
   input  wire logic [RRE_DATA_W-1:0]  literal_in,
   input  wire logic [RRE_FADDR_W-1:0] faddr_in,
   input  wire logic                   dest_in,
   input  wire logic [RRE_DATA_W-1:0]  fdata_in,
   input  wire logic [PC_W-1:0]        top_of_stack_in,
   input  wire logic                   carry_in,
   input  wire logic [RRE_DATA_W-1:0]  interrupt_control_reg_in,
   output logic                        busy_out,
   output logic                        done_out,
   output logic                        pop_out,
   output logic                        pc_load_out,
   output logic [PC_W-1:0]             pc_out,
   output logic                        w_we_out,
   output logic [RRE_DATA_W-1:0]       w_out,
   output logic                        f_we_out,
   output logic [RRE_FADDR_W-1:0]      f_addr_out,
   output logic [RRE_DATA_W-1:0]       f_data_out,
   output logic                        carry_we_out,
   output logic                        carry_out,
   output logic                        irq_ctrl_we_out,
   output logic [RRE_DATA_W-1:0]       irq_ctrl_out
);

   // Program counter widths the pc_out register can serve
   if (PC_W < 1 || PC_W > 32) begin : g_bad_pc_w
      $error("PC_W must lie between 1 and 32");
   end

   rre_state_t             state_q;
   rre_state_t             state_d;

   // Decode of the accepted instruction
   wire logic is_ret   = issue_in && !busy_out && (op_in != RRE_OP_ROT_LFT);
   wire logic is_rot   = issue_in && !busy_out && (op_in == RRE_OP_ROT_LFT);
   wire logic is_irq   = is_ret && (op_in == RRE_OP_RET_IRQ);
   wire logic is_lit   = is_ret && (op_in == RRE_OP_RET_LIT);
   wire logic to_file  = is_rot && (dest_in == RRE_DEST_F);
   wire logic to_work  = is_rot && (dest_in == RRE_DEST_W);

   // Rotated byte: each bit takes its lower neighbour, bit 0 the carry
   logic [RRE_DATA_W-1:0] rot_val;
   wire logic             rot_c = fdata_in[RRE_MSB_POS];
   assign rot_val[0] = carry_in;
   for (genvar b = 1; b < RRE_DATA_W; b++) begin : g_rot_bit
      assign rot_val[b] = fdata_in[b-1];
   end

   // Interrupt control copy with the enable bit forced high
   logic [RRE_DATA_W-1:0] ctrl_set;
   for (genvar b = 0; b < RRE_DATA_W; b++) begin : g_ctrl_bit
      if (b == RRE_IRQ_EN_POS) begin : g_en
         assign ctrl_set[b] = 1'b1;
      end else begin : g_keep
         assign ctrl_set[b] = interrupt_control_reg_in[b];
      end
   end

   // Sequencer: returns hold a second cycle, rotate does not
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         RRE_ST_IDLE: begin
            if (is_ret) begin
               state_d = RRE_ST_POP2;
            end
         end
         RRE_ST_POP2: begin
            state_d = RRE_ST_IDLE;
         end
      endcase
   end

   // State register and busy flag
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         state_q  <= RRE_ST_IDLE;
         busy_out <= 1'b0;
      end else begin
         state_q  <= state_d;
         busy_out <= (state_d == RRE_ST_POP2);
      end
   end

   // Stack pop, program counter load and completion strobe
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         pop_out     <= 1'b0;
         pc_load_out <= 1'b0;
         pc_out      <= '0;
         done_out    <= 1'b0;
      end else begin
         pop_out     <= is_ret;
         pc_load_out <= is_ret;
         if (is_ret) begin
            pc_out <= top_of_stack_in;
         end
         done_out <= is_rot || (state_q == RRE_ST_POP2);
      end
   end

   // Working register, file register and carry writes
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         w_we_out     <= 1'b0;
         w_out        <= RRE_BYTE_ZERO;
         f_we_out     <= 1'b0;
         f_addr_out   <= '0;
         f_data_out   <= RRE_BYTE_ZERO;
         carry_we_out <= 1'b0;
         carry_out    <= 1'b0;
      end else begin
         w_we_out     <= is_lit || to_work;
         f_we_out     <= to_file;
         carry_we_out <= is_rot;
         if (is_lit) begin
            w_out <= literal_in;
         end else if (to_work) begin
            w_out <= rot_val;
         end
         if (to_file) begin
            f_addr_out <= faddr_in;
            f_data_out <= rot_val;
         end
         if (is_rot) begin
            carry_out <= rot_c;
         end
      end
   end

   // Global interrupt enable write on interrupt return
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         irq_ctrl_we_out <= 1'b0;
         irq_ctrl_out    <= RRE_BYTE_ZERO;
      end else begin
         irq_ctrl_we_out <= is_irq;
         if (is_irq) begin
            irq_ctrl_out <= ctrl_set;
         end
      end
   end

   // Checks on the returns
   a_ret_two_cyc: assert property (
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      is_ret |=> busy_out ##1 (!busy_out && done_out))
      else $error("return did not take two cycles");
   a_ret_no_flag: assert property (
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      is_ret |=> (!carry_we_out && !f_we_out))
      else $error("return touched a status flag");
   a_sub_pc_load: assert property (
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      (is_ret && op_in == RRE_OP_RET_SUB) |=>
      (pc_load_out && pop_out && pc_out == $past(top_of_stack_in)))
      else $error("subroutine return pc wrong");
   a_sub_two_cyc: assert property (
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      (is_ret && op_in == RRE_OP_RET_SUB) |-> ##2 done_out)
      else $error("subroutine return not done in two");
   a_irq_pc_pop: assert property (
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      is_irq |=> (pop_out && pc_out == $past(top_of_stack_in)))
      else $error("interrupt return pc wrong");
   a_irq_enable_set: assert property (
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      is_irq |=> (irq_ctrl_we_out && irq_ctrl_out[RRE_IRQ_EN_POS]))
      else $error("enable bit not set");
   a_irq_keep_bits: assert property (
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      is_irq |=> (irq_ctrl_out[RRE_IRQ_EN_POS-1:0] ==
      $past(interrupt_control_reg_in[RRE_IRQ_EN_POS-1:0])))
      else $error("interrupt control bits lost");
   a_ctrl_irq_only: assert property (
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      irq_ctrl_we_out |-> $past(is_irq))
      else $error("interrupt control written outside return");
   a_lit_w_load: assert property (
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      is_lit |=> (w_we_out && w_out == $past(literal_in)
      && !carry_we_out))
      else $error("literal not loaded");
   a_lit_pc_pop: assert property (
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      is_lit |=> (pc_load_out && pop_out && pc_out == $past(top_of_stack_in))
      ##1 !pop_out)
      else $error("literal return pop wrong");

   // Checks on the rotate
   a_rot_value: assert property (
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      is_rot |=> (carry_out == $past(fdata_in[RRE_MSB_POS])
      && carry_we_out))
      else $error("rotate carry wrong");
   a_rot_result: assert property (
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      is_rot |=> ((f_we_out ? f_data_out : w_out) ==
      {$past(fdata_in[RRE_MSB_POS-1:0]), $past(carry_in)}))
      else $error("rotated byte wrong");
   a_rot_dest: assert property (
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      is_rot |=> (f_we_out == $past(dest_in)
      && w_we_out != $past(dest_in)))
      else $error("rotate destination wrong");
   a_rot_faddr: assert property (
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      to_file |=> (f_addr_out == $past(faddr_in)))
      else $error("rotate file address wrong");
   a_rot_one_cyc: assert property (
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      is_rot |=> (done_out && !busy_out && !pc_load_out && !pop_out))
      else $error("rotate not single cycle");

   // Issues made while busy must leave no trace
   a_busy_refuse: assert property (
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      busy_out |=> !(pop_out || w_we_out || f_we_out || carry_we_out))
      else $error("issue accepted while busy");
endmodule

// ### inc/rre_pkg.sv
package rre_pkg;
   // Opcode select for the four instructions this block executes
   typedef enum logic [1:0] {
      RRE_OP_RET_IRQ = 2'b00,
      RRE_OP_RET_SUB = 2'b01,
      RRE_OP_RET_LIT = 2'b10,
      RRE_OP_ROT_LFT = 2'b11
   } rre_op_t;

   // Execution sequencer states
   typedef enum logic [0:0] {
      RRE_ST_IDLE = 1'b0,
      RRE_ST_POP2 = 1'b1
   } rre_state_t;

   localparam int          RRE_DATA_W      = 8;
   localparam int          RRE_FADDR_W     = 7;
   localparam int          RRE_MSB_POS     = 7;
   localparam int          RRE_IRQ_EN_POS  = 7;
   localparam logic        RRE_DEST_W      = 1'b0;
   localparam logic        RRE_DEST_F      = 1'b1;
   localparam logic [7:0]  RRE_BYTE_ZERO   = 8'h00;
   localparam int          RRE_RET_CYCLES  = 2;
   localparam int          RRE_ROT_CYCLES  = 1;
endpackage

// ### tb/rre_exec_tb.sv
`timescale 1ns/1ns
module rre_exec_tb;
   import rre_pkg::*;
   logic                   ref_clk_in = 1'b0;
   logic                   rst_n_in = 1'b0;
   logic                   issue_in = 1'b0;
   rre_op_t                op_in = RRE_OP_RET_IRQ;
   logic [7:0]             literal_in = 8'h00;
   logic [6:0]             faddr_in = 7'h00;
   logic                   dest_in = 1'b0;
   logic [7:0]             fdata_in = 8'h00;
   logic [14:0]            top_of_stack_in = 15'h0000;
   logic                   carry_in = 1'b0;
   logic [7:0]             interrupt_control_reg_in = 8'h00;
   logic                   busy_out, done_out, pop_out, pc_load_out;
   logic                   w_we_out, f_we_out, carry_we_out, carry_out;
   logic                   irq_ctrl_we_out;
   logic [14:0]            pc_out;
   logic [7:0]             w_out, f_data_out, irq_ctrl_out;
   logic [6:0]             f_addr_out;
   logic [31:0]            r;
   integer                 seed = 32'hf5ba_372b;
   int                     checks = 0;
   int                     miscompares = 0;

   rre_exec uut (
      .ref_clk_in               (ref_clk_in),
      .rst_n_in                 (rst_n_in),
      .issue_in                 (issue_in),
      .op_in                    (op_in),
      .literal_in               (literal_in),
      .faddr_in                 (faddr_in),
      .dest_in                  (dest_in),
      .fdata_in                 (fdata_in),
      .top_of_stack_in          (top_of_stack_in),
      .carry_in                 (carry_in),
      .interrupt_control_reg_in (interrupt_control_reg_in),
      .busy_out                 (busy_out),
      .done_out                 (done_out),
      .pop_out                  (pop_out),
      .pc_load_out              (pc_load_out),
      .pc_out                   (pc_out),
      .w_we_out                 (w_we_out),
      .w_out                    (w_out),
      .f_we_out                 (f_we_out),
      .f_addr_out               (f_addr_out),
      .f_data_out               (f_data_out),
      .carry_we_out             (carry_we_out),
      .carry_out                (carry_out),
      .irq_ctrl_we_out          (irq_ctrl_we_out),
      .irq_ctrl_out             (irq_ctrl_out)
   );

   // Free running clock
   always #5 ref_clk_in = ~ref_clk_in;

   task automatic complete_run;
      $display("Checks %0d, miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Expected rotate: carry out on top, rotated byte below
   function automatic logic [8:0] exp_rot(input logic [7:0] fd,
                                          input logic cy);
      return {fd, cy};
   endfunction

   // Expected interrupt control: enable bit set, rest kept
   function automatic logic [7:0] exp_ctrl(input logic [7:0] v);
      return v | 8'h80;
   endfunction

   // One instruction; rep repeats a rotate or adds a refused issue
   task automatic exec(input rre_op_t op, input logic [7:0] fd,
                       input logic cy, input logic [7:0] lit, input logic rep);
      logic [31:0] q;
      logic [8:0]  rot;
      q = $random(seed);
      rot = exp_rot(fd, cy);
      @(posedge ref_clk_in);
      op_in <= op;
      fdata_in <= fd;
      carry_in <= cy;
      literal_in <= lit;
      dest_in <= q[0];
      faddr_in <= q[7:1];
      top_of_stack_in <= q[22:8];
      interrupt_control_reg_in <= q[30:23];
      issue_in <= 1'b1;
      @(posedge ref_clk_in);
      if (op == RRE_OP_ROT_LFT) begin
         for (int n = 0; n <= int'(rep); n++) begin
            if (n == int'(rep)) issue_in <= 1'b0;
            #1;
            chk(carry_we_out, 1'b1);
            chk(carry_out, rot[8]);
            chk(done_out, 1'b1);
            chk({w_we_out, f_we_out, pop_out}, {!q[0], q[0], 1'b0});
            chk(q[0] ? f_data_out : w_out, rot[7:0]);
            if (q[0]) chk(f_addr_out, q[7:1]);
            if (n < int'(rep)) @(posedge ref_clk_in);
         end
      end else begin
         if (rep) op_in <= RRE_OP_ROT_LFT;
         else issue_in <= 1'b0;
         #1;
         chk({pop_out, pc_load_out, busy_out, done_out}, 4'hE);
         chk(pc_out, q[22:8]);
         chk({carry_we_out, f_we_out}, 2'b00);
         chk(w_we_out, op == RRE_OP_RET_LIT);
         if (op == RRE_OP_RET_LIT) chk(w_out, lit);
         chk(irq_ctrl_we_out, op == RRE_OP_RET_IRQ);
         if (op == RRE_OP_RET_IRQ) chk(irq_ctrl_out, exp_ctrl(q[30:23]));
         @(posedge ref_clk_in);
         issue_in <= 1'b0;
         #1;
         chk({done_out, busy_out, pop_out}, 3'b100);
         chk({carry_we_out, w_we_out, f_we_out}, 3'b000);
      end
   endtask

   // Reset, corner cases, then random instructions
   initial begin
      repeat (16) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      #1;
      chk({busy_out, done_out, pop_out, w_we_out, carry_we_out}, 5'h00);
      exec(RRE_OP_ROT_LFT, 8'h80, 1'b0, 8'h00, 1'b1);
      exec(RRE_OP_ROT_LFT, 8'h7f, 1'b1, 8'h00, 1'b0);
      exec(RRE_OP_RET_LIT, 8'h00, 1'b0, 8'hff, 1'b1);
      exec(RRE_OP_RET_IRQ, 8'h00, 1'b0, 8'h00, 1'b1);
      exec(RRE_OP_RET_SUB, 8'h00, 1'b0, 8'h00, 1'b0);
      for (int i = 0; i < 60; i++) begin
         r = $random(seed);
         exec(rre_op_t'(r[1:0]), r[15:8], r[16], r[31:24], r[17]);
      end
      complete_run;
   end

   // Watchdog against a hang
   initial begin
      #50000;
      miscompares++;
      complete_run;
   end
endmodule
